/* hdl/clock_gen_config_and_reset.sv */
`timescale 1ns/1ps
module clock_gen_config_and_reset
  import clock_gen_pkg::*;
#(
  parameter logic [7:0] LEGACY_PRE_A = 8'h80,
  parameter logic [7:0] LEGACY_PRE_B = 8'h01,
  parameter logic [7:0] LEGACY_POST_A = 8'h83,
  parameter logic [7:0] LEGACY_POST_B = 8'h03
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Hard reset pin
  input wire logic rst_pin_n,
  // Frequency step pins
  input wire logic freq_inc,
  input wire logic freq_dec,
  // Register access from the serial decoder
  input wire reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Settings to the analog core
  output div_config_s div_cfg,
  output logic clocks_en,
  output logic pll_hold
);

  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0] shadow [SH_BYTES];
  logic [7:0] user_bank [USER_BANKS][SH_BYTES];
  state_e state;
  logic [IDX_W-1:0] idx;
  logic [CNT_W-1:0] init_cnt;
  logic [1:0] burned;
  logic [7:0] reinit_a, reinit_b, load_byte, bank_code, next_rdata;
  logic [OUT_DIVS-1:0] step_mask;
  div_config_s staged;
  logic [WIDE_W-1:0] step_word;
  logic [IN_DIVS-1:0] in_ok;
  logic [OUT_DIVS-1:0] out_ok;
  logic [R_DIVS-1:0] r_ok;
  logic fb_ok, wr_ok, hard_go, reload_go, soft_go, burn_go;
  logic apply_every, step_inc, step_dec, sh_hit, last_idx;
  logic [15:0] sh_off;

  // Factory image; this bank is constant and can never be burned
  function automatic logic [7:0] factory_byte(input logic [IDX_W-1:0] i);
    logic [7:0] b = 8'h00;
    for (int k = 0; k < IN_DIVS; k++) begin
      if (i == IDX_W'(SH_IN + IN_BYTES * k)) b = DEF_IN;
    end
    if (i == IDX_W'(SH_FB)) b = DEF_FB;
    if (i == IDX_W'(SH_FB + NUM_BYTES)) b = DEF_FB;
    for (int k = 0; k < OUT_DIVS; k++) begin
      if (i == IDX_W'(SH_OUT + FRAC_BYTES * k)) b = DEF_OUT_NUM;
      if (i == IDX_W'(SH_OUT + FRAC_BYTES * k + NUM_BYTES)) b = DEF_OUT_DEN;
    end
    for (int k = 0; k < R_DIVS; k++) begin
      if (i == IDX_W'(SH_R + R_BYTES * k)) b = DEF_R;
    end
    return b;
  endfunction

  // ****************************************
  // Access decode
  // ****************************************
  // Writes count only once the device is running
  assign wr_ok = req.wr && (state == ST_RUN);
  assign sh_off = req.addr - A_SHADOW;
  assign sh_hit = (req.addr >= A_SHADOW) && (sh_off < 16'(SH_BYTES));
  assign last_idx = (idx == IDX_W'(SH_BYTES - 1));
  // The pin acts even while busy, like a power cycle
  assign hard_go = !rst_pin_n
    || (wr_ok && req.addr == A_FULL && req.wdata[FULL_BIT]);
  assign reload_go = wr_ok && req.addr == A_RELOAD && req.wdata[RELOAD_BIT];
  assign soft_go = wr_ok && req.addr == A_PARTIAL
    && req.wdata[PARTIAL_BIT];
  // Both user banks spent: further burn commands are dropped
  assign burn_go = wr_ok && req.addr == A_MEMWR
    && req.wdata == BURN_CMD && burned < 2'(USER_BANKS);
  assign apply_every = (state == ST_INIT)
    && (init_cnt == CNT_W'(INIT_CYCLES - 1));
  assign step_inc = (state == ST_RUN) && (freq_inc
    || (wr_ok && req.addr == A_STEP && req.wdata[STEP_INC_BIT]));
  assign step_dec = (state == ST_RUN) && (freq_dec
    || (wr_ok && req.addr == A_STEP && req.wdata[STEP_DEC_BIT]));
  assign load_byte = (burned == 2'b00) ? factory_byte(idx)
    : user_bank[burned[1]][idx];

  // ****************************************
  // Sequencer
  // ****************************************
  // Load image, wait out init, run; burns copy shadow to a user bank
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_LOAD;
      idx <= '0;
      init_cnt <= '0;
    end else if (hard_go || reload_go) begin
      state <= ST_LOAD;
      idx <= '0;
    end else begin
      unique case (state)
        ST_LOAD: begin
          idx <= last_idx ? '0 : idx + 1'b1;
          if (last_idx) begin
            state <= ST_INIT;
            init_cnt <= '0;
          end
        end
        ST_INIT: begin
          init_cnt <= init_cnt + 1'b1;
          if (apply_every) state <= ST_RUN;
        end
        ST_RUN: begin
          if (soft_go) begin
            state <= ST_INIT;
            init_cnt <= '0;
          end else if (burn_go) begin
            state <= ST_BURN;
            idx <= '0;
          end
        end
        ST_BURN: begin
          idx <= last_idx ? '0 : idx + 1'b1;
          if (last_idx) state <= ST_RUN;
        end
      endcase
    end
  end

  // Bank usage survives hard resets; only power-on clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      burned <= '0;
    end else if (state == ST_BURN && last_idx && !hard_go) begin
      burned <= burned + 1'b1;
    end
  end

  // User bank burn, one byte a cycle
  always_ff @(posedge clk) begin
    if (state == ST_BURN) begin
      user_bank[burned[0]][idx] <= shadow[idx];
    end
  end

  // ****************************************
  // Shadow registers
  // ****************************************
  // Host writes land here and never touch the live dividers
  always_ff @(posedge clk) begin
    if (state == ST_LOAD) begin
      shadow[idx] <= load_byte;
    end else if (wr_ok && sh_hit) begin
      shadow[sh_off[IDX_W-1:0]] <= req.wdata;
    end
  end

  // Field view of the shadow bytes
  always_comb begin
    logic [WIDE_W-1:0] w;
    w = '0;
    staged = '0;
    for (int i = 0; i < IN_DIVS; i++) begin
      staged.in_div[i] = {shadow[SH_IN + IN_BYTES * i + 1],
                          shadow[SH_IN + IN_BYTES * i]};
    end
    staged.prescale = shadow[SH_PRE][PRE_W-1:0];
    for (int k = 0; k < NUM_BYTES; k++) begin
      w[BYTE_W * k +: BYTE_W] = shadow[SH_FB + k];
    end
    staged.fb_num = w[NUM_W-1:0];
    for (int k = 0; k < DEN_BYTES; k++) begin
      staged.fb_den[BYTE_W * k +: BYTE_W] = shadow[SH_FB + NUM_BYTES + k];
    end
    for (int j = 0; j < OUT_DIVS; j++) begin
      for (int k = 0; k < NUM_BYTES; k++) begin
        w[BYTE_W * k +: BYTE_W] = shadow[SH_OUT + FRAC_BYTES * j + k];
      end
      staged.out_num[j] = w[NUM_W-1:0];
      for (int k = 0; k < DEN_BYTES; k++) begin
        staged.out_den[j][BYTE_W * k +: BYTE_W] =
          shadow[SH_OUT + FRAC_BYTES * j + NUM_BYTES + k];
      end
    end
    for (int r = 0; r < R_DIVS; r++) begin
      for (int k = 0; k < R_BYTES; k++) begin
        w[BYTE_W * k +: BYTE_W] = shadow[SH_R + R_BYTES * r + k];
      end
      staged.r_div[r] = w[R_W-1:0];
    end
    for (int k = 0; k < NUM_BYTES; k++) begin
      w[BYTE_W * k +: BYTE_W] = shadow[SH_STEP + k];
    end
    step_word = w;
  end

  // ****************************************
  // Range checks
  // ****************************************
  // Out-of-range values are refused and the old ratio stays in use
  assign fb_ok = (staged.fb_den != '0);
  for (genvar g = 0; g < IN_DIVS; g++) begin : g_in
    assign in_ok[g] = (staged.in_div[g] != '0);
  end
  for (genvar g = 0; g < OUT_DIVS; g++) begin : g_out
    logic [WIDE_W-1:0] num_w;
    logic [WIDE_W-1:0] den_w;
    assign num_w = WIDE_W'(staged.out_num[g]);
    assign den_w = WIDE_W'(staged.out_den[g]);
    // Integer part of num/den must sit in 10..4095
    assign out_ok[g] = (den_w != '0)
      && (num_w >= den_w * WIDE_W'(OUT_MIN))
      && (num_w < (den_w << OUT_MAX_SHIFT));
  end
  for (genvar g = 0; g < R_DIVS; g++) begin : g_r
    // 25-bit field tops out at 2^25-2 once odd values are refused
    assign r_ok[g] = (staged.r_div[g] != '0)
      && !staged.r_div[g][0];
  end

  // ****************************************
  // Active dividers
  // ****************************************
  // Whole fields copy in one edge so no half-written ratio is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cfg <= '0;
    end else begin
      for (int i = 0; i < IN_DIVS; i++) begin
        if ((apply_every || (wr_ok && req.addr == A_UPD_A
             && req.wdata[i])) && in_ok[i]) begin
          div_cfg.in_div[i] <= staged.in_div[i];
        end
      end
      if ((apply_every || (wr_ok && req.addr == A_UPD_A
           && req.wdata[UPD_FB_BIT])) && fb_ok) begin
        div_cfg.fb_num <= staged.fb_num;
        div_cfg.fb_den <= staged.fb_den;
        div_cfg.prescale <= staged.prescale;
      end
      for (int j = 0; j < OUT_DIVS; j++) begin
        if ((apply_every || (wr_ok && req.addr == A_UPD_B && req.wdata[j])
             || (wr_ok && req.addr == A_UPD_A && req.wdata[UPD_ALL_BIT]))
            && out_ok[j]) begin
          div_cfg.out_num[j] <= staged.out_num[j];
          div_cfg.out_den[j] <= staged.out_den[j];
        end else if (step_inc && step_mask[j]) begin
          div_cfg.out_num[j] <= div_cfg.out_num[j]
            + step_word[NUM_W-1:0];
        end else if (step_dec && step_mask[j]) begin
          div_cfg.out_num[j] <= div_cfg.out_num[j]
            - step_word[NUM_W-1:0];
        end
      end
      for (int r = 0; r < R_DIVS; r++) begin
        if ((apply_every || (wr_ok && req.addr == A_UPD_R && req.wdata[r]))
            && r_ok[r]) begin
          div_cfg.r_div[r] <= staged.r_div[r];
        end
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Legacy codes are folded to current ones so reads match new software
  always_ff @(posedge clk) begin
    if (rst || hard_go) begin
      reinit_a <= POST_A;
      reinit_b <= POST_B;
      step_mask <= '0;
    end else begin
      if (wr_ok && req.addr == A_REINIT_A) begin
        reinit_a <= (req.wdata == LEGACY_PRE_A) ? PRE_A
          : (req.wdata == LEGACY_POST_A) ? POST_A : req.wdata;
      end
      if (wr_ok && req.addr == A_REINIT_B) begin
        reinit_b <= (req.wdata == LEGACY_PRE_B) ? PRE_B
          : (req.wdata == LEGACY_POST_B) ? POST_B : req.wdata;
      end
      if (wr_ok && req.addr == A_STEP_MASK) begin
        step_mask <= req.wdata[OUT_DIVS-1:0];
      end
    end
  end

  // Clocks run only after init; the preamble holds the PLL
  always_ff @(posedge clk) begin
    if (rst) begin
      clocks_en <= 1'b0;
      pll_hold <= 1'b0;
    end else begin
      clocks_en <= (state == ST_RUN) || (state == ST_BURN);
      pll_hold <= (reinit_a == PRE_A);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Trigger and update bits are strobes and always read back as zero
  always_comb begin
    unique case (burned)
      2'b00: bank_code = BANK_FACTORY;
      2'b01: bank_code = BANK_ONE;
      default: bank_code = BANK_TWO;
    endcase
    next_rdata = 8'h00;
    if (state == ST_BURN) begin
      // During a burn only the ready register is decoded; every other read returns zero
      if (req.addr == A_READY) next_rdata = BUSY_VAL;
    end else if (sh_hit) begin
      next_rdata = shadow[sh_off[IDX_W-1:0]];
    end else if (req.addr == A_READY) begin
      next_rdata = READY_VAL;
    end else if (req.addr == A_BANK) begin
      next_rdata = bank_code;
    end else if (req.addr == A_REINIT_A) begin
      next_rdata = reinit_a;
    end else if (req.addr == A_REINIT_B) begin
      next_rdata = reinit_b;
    end else if (req.addr == A_STEP_MASK) begin
      next_rdata = 8'(step_mask);
    end
  end

  // One-cycle read answer; no answer at all while initializing
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && (state == ST_RUN || state == ST_BURN);
      if (req.rd) rdata <= next_rdata;
    end
  end

endmodule

/* include/clock_gen_pkg.sv */
package clock_gen_pkg;

  // ****************************************
  // Divider geometry
  // ****************************************
  localparam int IN_DIVS = 4;
  localparam int OUT_DIVS = 5;
  localparam int R_DIVS = 4;
  localparam int IN_W = 16;
  localparam int PRE_W = 2;
  localparam int NUM_W = 44;
  localparam int DEN_W = 32;
  localparam int R_W = 25;
  localparam int WIDE_W = 48;
  localparam int BYTE_W = 8;
  localparam int OUT_MIN = 10;
  localparam int OUT_MAX_SHIFT = 12;

  // ****************************************
  // Shadow byte layout (little endian fields)
  // ****************************************
  localparam int SH_IN = 0;
  localparam int IN_BYTES = 2;
  localparam int SH_FB = 8;
  localparam int SH_OUT = 18;
  localparam int FRAC_BYTES = 10;
  localparam int NUM_BYTES = 6;
  localparam int DEN_BYTES = 4;
  localparam int SH_R = 68;
  localparam int R_BYTES = 4;
  localparam int SH_STEP = 84;
  localparam int SH_PRE = 90;
  localparam int SH_BYTES = 91;
  localparam int IDX_W = 7;
  localparam int USER_BANKS = 2;

  // ****************************************
  // Register addresses and bits
  // ****************************************
  localparam logic [15:0] A_PARTIAL = 16'h001C;
  localparam int PARTIAL_BIT = 0;
  localparam logic [15:0] A_FULL = 16'h001E;
  localparam int FULL_BIT = 1;
  localparam logic [15:0] A_BANK = 16'h00E2;
  localparam logic [15:0] A_MEMWR = 16'h00E3;
  localparam logic [15:0] A_RELOAD = 16'h00E4;
  localparam int RELOAD_BIT = 0;
  localparam logic [15:0] A_READY = 16'h00FE;
  localparam logic [15:0] A_REINIT_A = 16'h0B24;
  localparam logic [15:0] A_REINIT_B = 16'h0B25;
  localparam logic [15:0] A_SHADOW = 16'h0300;
  localparam logic [15:0] A_UPD_A = 16'h0360;
  localparam logic [15:0] A_UPD_B = 16'h0361;
  localparam logic [15:0] A_UPD_R = 16'h0362;
  localparam logic [15:0] A_STEP = 16'h0363;
  localparam logic [15:0] A_STEP_MASK = 16'h0364;
  localparam int UPD_FB_BIT = 4;
  localparam int UPD_ALL_BIT = 5;
  localparam int STEP_INC_BIT = 0;
  localparam int STEP_DEC_BIT = 1;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0] READY_VAL = 8'h0F;
  localparam logic [7:0] BUSY_VAL = 8'h00;
  localparam logic [7:0] BURN_CMD = 8'hC7;
  localparam logic [7:0] PRE_A = 8'hC0;
  localparam logic [7:0] PRE_B = 8'h00;
  localparam logic [7:0] POST_A = 8'hC3;
  localparam logic [7:0] POST_B = 8'h02;
  localparam logic [7:0] BANK_FACTORY = 8'h03;
  localparam logic [7:0] BANK_ONE = 8'h0F;
  localparam logic [7:0] BANK_TWO = 8'h3F;
  localparam logic [7:0] DEF_IN = 8'h01;
  localparam logic [7:0] DEF_FB = 8'h01;
  localparam logic [7:0] DEF_OUT_NUM = 8'h0A;
  localparam logic [7:0] DEF_OUT_DEN = 8'h01;
  localparam logic [7:0] DEF_R = 8'h02;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001,
    ST_INIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_BURN = 4'b1000
  } state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [IN_DIVS-1:0][IN_W-1:0] in_div;
    logic [PRE_W-1:0] prescale;
    logic [NUM_W-1:0] fb_num;
    logic [DEN_W-1:0] fb_den;
    logic [OUT_DIVS-1:0][NUM_W-1:0] out_num;
    logic [OUT_DIVS-1:0][DEN_W-1:0] out_den;
    logic [R_DIVS-1:0][R_W-1:0] r_div;
  } div_config_s;

endpackage

/* verification/clock_gen_monitor.sv */
`timescale 1ns/1ps
module clock_gen_monitor
  import clock_gen_pkg::*;
#(
  parameter logic [7:0] LEGACY_PRE_A = 8'h80
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and requests
  input wire logic rst_pin_n,
  input wire logic freq_inc,
  input wire logic freq_dec,
  input wire reg_req_s req,
  // Answers and settings
  input wire logic rvalid,
  input wire div_config_s div_cfg,
  input wire logic clocks_en,
  input wire logic pll_hold
);
  logic prev_wr;
  logic prev_pin;
  logic prev_en;
  logic [15:0] prev_addr;
  logic [7:0] prev_data;
  logic steady;
  logic init_cause;
  logic r_odd;

  // Last cycle's view; a reset request must not look like steady running
  always_ff @(posedge clk) begin
    prev_wr <= req.wr && !rst;
    prev_pin <= rst_pin_n && !rst;
    prev_en <= clocks_en && !rst;
    prev_addr <= req.addr;
    prev_data <= req.wdata;
  end

  assign steady = clocks_en && prev_en && !prev_wr && prev_pin;
  assign init_cause = !prev_en || !prev_pin ||
    (prev_wr && (prev_addr == A_FULL || prev_addr == A_RELOAD));

  // Any odd final divider ratio
  always_comb begin
    r_odd = 1'b0;
    for (int k = 0; k < R_DIVS; k++) begin
      r_odd = r_odd | div_cfg.r_div[k][0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hold_write;
    steady && req.wr && req.addr == A_REINIT_A &&
      (req.wdata == PRE_A || req.wdata == LEGACY_PRE_A);
  endsequence
  sequence s_pll_held;
    ##[1:2] pll_hold;
  endsequence

  reset_quiet_a: assert property ($fell(rst) |->
    !clocks_en && !rvalid && div_cfg == '0) else $error("reset outputs");
  read_answer_a: assert property (steady && req.rd |=> rvalid)
    else $error("read not answered");
  read_cause_a: assert property (rvalid |-> $past(req.rd))
    else $error("rvalid without read");
  pin_read_a: assert property (req.rd && !rst_pin_n |=> !rvalid)
    else $error("read answered in hard reset");
  pll_hold_a: assert property (s_hold_write |-> s_pll_held)
    else $error("pll hold missing");
  in_update_a: assert property ($changed(div_cfg.in_div) |->
    init_cause || (prev_wr && prev_addr == A_UPD_A))
    else $error("input divider changed without update");
  fb_update_a: assert property ($changed(div_cfg.fb_num) |->
    init_cause || (prev_wr && prev_addr == A_UPD_A && prev_data[UPD_FB_BIT]))
    else $error("feedback changed without update");
  out_update_a: assert property ($changed(div_cfg.out_num) |->
    init_cause || $past(freq_inc || freq_dec) || (prev_wr &&
    (prev_addr == A_UPD_A || prev_addr == A_UPD_B || prev_addr == A_STEP)))
    else $error("output divider changed without cause");
  r_even_a: assert property (steady |-> !r_odd)
    else $error("odd final divider");
  out_range_a: assert property (steady |->
    div_cfg.out_num[0] >= NUM_W'(OUT_MIN) * div_cfg.out_den[0] &&
    div_cfg.out_num[0] < (NUM_W'(div_cfg.out_den[0]) << OUT_MAX_SHIFT))
    else $error("output ratio out of range");
endmodule

bind clock_gen_config_and_reset clock_gen_monitor #(
  .LEGACY_PRE_A(LEGACY_PRE_A)
) i_clock_gen_monitor (
  .clk(clk), .rst(rst), .rst_pin_n(rst_pin_n), .freq_inc(freq_inc),
  .freq_dec(freq_dec), .req(req), .rvalid(rvalid), .div_cfg(div_cfg),
  .clocks_en(clocks_en), .pll_hold(pll_hold)
);

/* verification/clock_gen_host.sv */
`timescale 1ns/1ps
module clock_gen_host
  import clock_gen_pkg::*;
#(
  parameter int SETTLE = 50
) (
  // Clock
  input wire logic clk,
  // Register port
  output reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    req = '0;
  end

  // Released fields are flipped so a stale value never passes as valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    d = rdata;
    v = rvalid;
    req.rd = 1'b0;
    req.addr = ~a;
  endtask

  // Little-endian field, n bytes of the value
  task automatic wr_field(input logic [15:0] a, input logic [WIDE_W-1:0] x,
                          input int n);
    for (int i = 0; i < n; i++) begin
      wr(a + 16'(i), x[i*8 +: 8]);
    end
  endtask

  // Only the ready register is touched while the device is busy
  task automatic wait_ready(output logic ok);
    logic [7:0] d;
    logic v;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      rd(A_READY, d, v);
      ok = v && d === READY_VAL;
    end
  endtask

  // Feedback change wrapped in the reinit steps; wait scaled down
  task automatic pll_reinit(input logic [WIDE_W-1:0] num);
    wr(A_REINIT_A, PRE_A);
    wr(A_REINIT_B, PRE_B);
    repeat (SETTLE) @(posedge clk);
    wr_field(A_SHADOW + 16'(SH_FB), num, NUM_BYTES);
    wr(A_UPD_A, 8'(1 << UPD_FB_BIT));
    wr(A_PARTIAL, 8'h01);
    repeat (INIT_CYCLES + 20) @(posedge clk);
    wr(A_REINIT_A, POST_A);
    wr(A_REINIT_B, POST_B);
  endtask
endmodule

/* verification/clock_gen_config_and_reset_test.sv */
`timescale 1ns/1ps
module clock_gen_config_and_reset_test
  import clock_gen_pkg::*;
  ;
  localparam logic [7:0] OLD_POST_A = 8'h83;
  localparam logic [7:0] OLD_PRE_B = 8'h01;
  logic clk;
  logic rst;
  logic rst_pin_n;
  logic freq_inc;
  logic freq_dec;
  reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  div_config_s div_cfg;
  logic clocks_en;
  logic pll_hold;
  int num_errors = 0;
  int checks = 0;

  clock_gen_config_and_reset #(
    .LEGACY_POST_A(OLD_POST_A), .LEGACY_PRE_B(OLD_PRE_B)
  ) i_clock_gen_config_and_reset (
    .clk(clk), .rst(rst), .rst_pin_n(rst_pin_n), .freq_inc(freq_inc),
    .freq_dec(freq_dec), .req(req), .rdata(rdata), .rvalid(rvalid),
    .div_cfg(div_cfg), .clocks_en(clocks_en), .pll_hold(pll_hold)
  );
  clock_gen_host #(.SETTLE(100)) i_clock_gen_host (
    .clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check_word(input string n, input logic [WIDE_W-1:0] e,
                            input logic [WIDE_W-1:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic reg_is(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_clock_gen_host.rd(a, d, v);
    check_bit("rvalid", 1'b1, v);
    check_word("rdata", WIDE_W'(e), WIDE_W'(d));
  endtask
  function automatic logic [15:0] sh(input int o);
    return A_SHADOW + 16'(o);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_clock_gen_host.wr(a, d);
  endtask
  task automatic fw(input int o, input logic [WIDE_W-1:0] x, input int n);
    i_clock_gen_host.wr_field(sh(o), x, n);
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic up);
    @(posedge clk);
    #1;
    freq_inc = up;
    freq_dec = !up;
    @(posedge clk);
    #1;
    freq_inc = 1'b0;
    freq_dec = 1'b0;
    wait_cycles(1);
  endtask
  task automatic out_is(input int j, input logic [WIDE_W-1:0] e);
    check_word("out_num", e, WIDE_W'(div_cfg.out_num[j]));
  endtask
  task automatic in_is(input int j, input logic [WIDE_W-1:0] e);
    check_word("in_div", e, WIDE_W'(div_cfg.in_div[j]));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_power_up;
    logic [7:0] d;
    logic v;
    check_bit("clocks_en", 1'b0, clocks_en);
    i_clock_gen_host.rd(A_READY, d, v);
    check_bit("early rvalid", 1'b0, v);
    wait_cycles(600);
    check_bit("clocks_en", 1'b1, clocks_en);
    reg_is(A_READY, READY_VAL);
    reg_is(A_BANK, BANK_FACTORY);
    reg_is(A_REINIT_A, POST_A);
    reg_is(16'h0100, 8'h00);
    in_is(0, WIDE_W'(DEF_IN));
    out_is(0, WIDE_W'(DEF_OUT_NUM));
  endtask

  // Ratio 75 keeps the detector at 10 MHz or more
  task automatic test_input_div;
    fw(SH_IN, 48'h4B, IN_BYTES);
    fw(SH_IN + IN_BYTES, 48'h0, IN_BYTES);
    in_is(0, WIDE_W'(DEF_IN));
    wr(A_UPD_A, 8'h03);
    in_is(0, 48'h4B);
    in_is(1, WIDE_W'(DEF_IN));
  endtask

  task automatic test_feedback;
    fw(SH_PRE, 48'h3, 1);
    fw(SH_FB + NUM_BYTES, 48'h1234_5678, DEN_BYTES);
    check_word("fb_den", WIDE_W'(DEF_FB), WIDE_W'(div_cfg.fb_den));
    fork
      i_clock_gen_host.pll_reinit(48'h0ABC_DEF0_1234);
      begin
        wait_cycles(40);
        check_bit("pll_hold", 1'b1, pll_hold);
      end
    join
    check_word("fb_num", 48'h0ABC_DEF0_1234, WIDE_W'(div_cfg.fb_num));
    check_word("fb_den", 48'h1234_5678, WIDE_W'(div_cfg.fb_den));
    check_word("prescale", 48'h3, WIDE_W'(div_cfg.prescale));
    check_bit("pll_hold", 1'b0, pll_hold);
  endtask

  task automatic test_out_div;
    logic [WIDE_W-1:0] nums [5] = '{48'd10, 48'd4095, 48'd9, 48'd4096, 48'd20};
    for (int j = 1; j < OUT_DIVS; j++) begin
      fw(SH_OUT + FRAC_BYTES * j, nums[j], NUM_BYTES);
    end
    wr(A_UPD_B, 8'h02);
    out_is(1, 48'd4095);
    out_is(4, WIDE_W'(DEF_OUT_NUM));
    wr(A_UPD_A, 8'(1 << UPD_ALL_BIT));
    out_is(4, 48'd20);
    out_is(2, WIDE_W'(DEF_OUT_NUM));
    out_is(3, WIDE_W'(DEF_OUT_NUM));
  endtask

  task automatic test_r_div;
    fw(SH_R, 48'h3, R_BYTES);
    fw(SH_R + R_BYTES, 48'h1FF_FFFE, R_BYTES);
    wr(A_UPD_R, 8'h03);
    check_word("r_div0", WIDE_W'(DEF_R), WIDE_W'(div_cfg.r_div[0]));
    check_word("r_div1", 48'h1FF_FFFE, WIDE_W'(div_cfg.r_div[1]));
  endtask

  task automatic test_step;
    fw(SH_STEP, 48'h5, 6);
    wr(A_STEP_MASK, 8'h01);
    pulse(1'b1);
    out_is(0, 48'd15);
    wr(A_STEP, 8'h01);
    out_is(0, 48'd20);
    pulse(1'b0);
    out_is(0, 48'd15);
    wr(A_STEP, 8'h02);
    out_is(0, 48'd10);
    out_is(1, 48'd4095);
  endtask

  task automatic test_legacy;
    wr(A_REINIT_A, OLD_POST_A);
    reg_is(A_REINIT_A, POST_A);
    wr(A_REINIT_B, OLD_PRE_B);
    reg_is(A_REINIT_B, PRE_B);
  endtask

  task automatic test_partial;
    fw(SH_IN + 2 * IN_BYTES, 48'h5, IN_BYTES);
    wr(A_PARTIAL, 8'h01);
    wait_cycles(2);
    check_bit("clocks_en", 1'b0, clocks_en);
    wait_cycles(INIT_CYCLES + 20);
    in_is(2, 48'h5);
    in_is(0, 48'h4B);
    reg_is(A_PARTIAL, 8'h00);
    reg_is(A_UPD_A, 8'h00);
  endtask

  task automatic test_burn;
    logic ok;
    logic [7:0] codes [3] = '{BANK_ONE, BANK_TWO, BANK_TWO};
    for (int k = 0; k < 3; k++) begin
      wr(A_MEMWR, BURN_CMD);
      if (k < 2) begin
        reg_is(A_READY, BUSY_VAL);
      end
      i_clock_gen_host.wait_ready(ok);
      check_bit("ready", 1'b1, ok);
      reg_is(A_BANK, codes[k]);
    end
    // Reload brings the burned image back over a later host edit
    fw(SH_IN + 3 * IN_BYTES, 48'h7, IN_BYTES);
    wr(A_RELOAD, 8'h01);
    i_clock_gen_host.wait_ready(ok);
    check_bit("reload ready", 1'b1, ok);
    reg_is(sh(SH_IN + 3 * IN_BYTES), DEF_IN);
  endtask

  task automatic test_hard_reset;
    logic [7:0] d;
    logic v;
    wr(A_FULL, 8'h02);
    wait_cycles(2);
    check_bit("clocks_en", 1'b0, clocks_en);
    wait_cycles(600);
    reg_is(A_REINIT_B, POST_B);
    in_is(0, 48'h4B);
    rst_pin_n = 1'b0;
    i_clock_gen_host.rd(A_READY, d, v);
    check_bit("pin rvalid", 1'b0, v);
    check_bit("clocks_en", 1'b0, clocks_en);
    rst_pin_n = 1'b1;
    wait_cycles(600);
    reg_is(A_READY, READY_VAL);
    reg_is(A_BANK, BANK_TWO);
  endtask

  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Run needs about 4000 cycles; this allows several times that
  initial begin
    #200000;
    num_errors++;
    conclude;
  end

  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b1;
    freq_inc = 1'b0;
    freq_dec = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    test_power_up;
    test_input_div;
    test_feedback;
    test_out_div;
    test_r_div;
    test_step;
    test_legacy;
    test_partial;
    test_burn;
    test_hard_reset;
    conclude;
  end
endmodule
